// file: design/acc_defs.vh
`ifndef ACC_DEFS_VH
`define ACC_DEFS_VH

// Register indexes (byte address = index * 4)
`define ACC_IDX_SETUP        16'h7160
`define ACC_IDX_CTRL         16'h7161
`define ACC_IDX_DATA         16'h7162
`define ACC_IDX_CHAN         16'h7163
`define ACC_ADDR_SETUP       18'h1_C580
`define ACC_ADDR_CTRL        18'h1_C584
`define ACC_ADDR_DATA        18'h1_C588
`define ACC_ADDR_CHAN        18'h1_C58C

// Setup fields
`define ACC_SET_BIAS         15
`define ACC_SET_EN           14
`define ACC_SET_DIV_HI       10
`define ACC_SET_DIV_LO       9
`define ACC_SET_EXT          8
`define ACC_SET_TMR          7
`define ACC_SETUP_RST        16'h8000
`define ACC_SETUP_MASK       16'hC780

// Control fields
`define ACC_CTL_FLAG         15
`define ACC_CTL_IE           14
`define ACC_CTL_RDY          7
`define ACC_CTL_START        6
`define ACC_CTL_SEL_HI       2

// Data register
`define ACC_RES_RST          10'h3FF
`define ACC_RES_LSB          6

// Conversion length in converter clocks, divider base
`define ACC_SAR_BITS         4'hA
`define ACC_SAMPLE_CLKS      4'h4
`define ACC_DIV_BASE         7'h08

`endif

// file: design/acc_clk_div.v
`timescale 1ns/1ps
`default_nettype none
// Converter clock tick generator: one pulse every 8/16/32/64 core clocks
module acc_clk_div (
  // Clock and reset
  input  wire       sys_clk,
  input  wire       resetn,
  // Control
  input  wire       run,
  input  wire [1:0] divSel,
  // Tick out
  output wire       tick
);
  `include "acc_defs.vh"

  reg  [6:0] cntReg;
  wire [6:0] limit;

  assign limit = (`ACC_DIV_BASE << divSel) - 7'h01;
  assign tick  = run && (cntReg >= limit);

  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cntReg <= 7'h00;
    end else if (!run || tick) begin
      cntReg <= 7'h00;
    end else begin
      cntReg <= cntReg + 7'h01;
    end
  end
endmodule
`default_nettype wire

// file: design/adc_conversion_control.v
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_control (
  // Clock and reset
  input  wire        sys_clk,
  input  wire        resetn,
  // Register port
  input  wire [17:0] regAddr,
  input  wire [15:0] regWdata,
  input  wire        regWr,
  input  wire        regRd,
  output reg  [15:0] regRdata,
  // Triggers and power state
  input  wire        triggerInputPin,
  input  wire        timerEvent,
  input  wire        standbyMode,
  // Analog core
  output wire        biasPowerOn,
  output wire        sampleHold,
  output wire        sarActive,
  output wire [2:0]  channelLatched,
  output wire [7:0]  pinAnalogEnable,
  input  wire        compareIn,
  // Interrupt request
  output wire        convIrq
);
  `include "acc_defs.vh"

  localparam ST_IDLE   = 2'd0;
  localparam ST_SAMPLE = 2'd1;
  localparam ST_SAR    = 2'd2;
  localparam ST_DONE   = 2'd3;

  reg  [15:0] setupReg;
  reg         flagReg;
  reg         irqEnReg;
  reg         readyReg;
  reg  [2:0]  selReg;
  reg  [7:0]  pinEnReg;
  reg  [9:0]  resultReg;
  reg  [9:0]  sarReg;
  reg  [9:0]  trialReg;
  reg  [2:0]  chanReg;
  reg  [1:0]  stateReg;
  reg  [3:0]  cntReg;
  reg         trigPrevReg;
  reg         firstPendReg;
  reg         enPrevReg;
  reg  [15:0] readMux;

  wire        wrSetup = regWr && (regAddr == `ACC_ADDR_SETUP);
  wire        wrCtrl  = regWr && (regAddr == `ACC_ADDR_CTRL);
  wire        wrChan  = regWr && (regAddr == `ACC_ADDR_CHAN);
  wire        convEn  = setupReg[`ACC_SET_EN];
  wire        tick;
  wire        extReq;
  wire        tmrReq;
  wire        manReq;
  wire        startReq;
  wire        doneNow;
  wire        dummyNow;
  wire        loadNow;
  wire        idleNow;
  wire        anyReq;
  wire        flagClr;
  wire        sampleLast;
  wire        sarLast;
  wire        sampleDone;
  wire        divRun;
  wire [2:0]  selNow;
  wire [9:0]  sarNext;
  wire [15:0] ctrlView;
  wire [15:0] dataView;
  wire [15:0] chanView;

  assign extReq   = setupReg[`ACC_SET_EXT] && triggerInputPin && !trigPrevReg;
  assign tmrReq   = setupReg[`ACC_SET_TMR] && timerEvent;
  assign manReq   = wrCtrl && regWdata[`ACC_CTL_START];
  assign idleNow  = (stateReg == ST_IDLE);
  assign anyReq   = extReq || tmrReq || manReq;
  // Busy or disabled converter drops the request, nothing is queued
  assign startReq = convEn && idleNow && anyReq;
  assign doneNow  = (stateReg == ST_DONE);
  assign flagClr  = wrCtrl && regWdata[`ACC_CTL_FLAG];
  // A start written together with a channel converts that new channel
  assign selNow   = wrCtrl ? regWdata[`ACC_CTL_SEL_HI:0] : selReg;
  assign sampleLast = (cntReg == `ACC_SAMPLE_CLKS - 4'h1);
  assign sarLast    = (cntReg == `ACC_SAR_BITS - 4'h1);
  assign sampleDone = sampleHold && tick && sampleLast;
  assign divRun     = convEn && (sampleHold || sarActive);
  // Dummy completion after the first enable from reset
  assign dummyNow = firstPendReg && convEn && !enPrevReg && (stateReg == ST_IDLE);
  assign loadNow  = doneNow || dummyNow;

  assign biasPowerOn     = setupReg[`ACC_SET_BIAS] && !standbyMode;
  assign sampleHold      = (stateReg == ST_SAMPLE);
  assign sarActive       = (stateReg == ST_SAR);
  assign channelLatched  = chanReg;
  assign pinAnalogEnable = pinEnReg;
  assign convIrq         = flagReg && irqEnReg;
  assign ctrlView        = {flagReg, irqEnReg, 6'h00, readyReg, 4'h0, selReg};
  assign dataView        = {resultReg, 6'h00};
  assign chanView        = {8'h00, pinEnReg};

  // Trial bit settles to the comparator answer, the next one below is tried
  genvar bitIdx;
  generate
    for (bitIdx = 0; bitIdx < 10; bitIdx = bitIdx + 1) begin : g_sar
      if (bitIdx == 9) begin : g_top
        assign sarNext[bitIdx] = trialReg[bitIdx] ? compareIn : sarReg[bitIdx];
      end else begin : g_low
        assign sarNext[bitIdx] = trialReg[bitIdx]     ? compareIn :
                                 trialReg[bitIdx + 1] ? 1'b1 : sarReg[bitIdx];
      end
    end
  endgenerate

  acc_clk_div uDiv (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .run     (divRun),
    .divSel  (setupReg[`ACC_SET_DIV_HI:`ACC_SET_DIV_LO]),
    .tick    (tick)
  );

  // Register writes
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      setupReg <= `ACC_SETUP_RST;
      irqEnReg <= 1'b0;
      selReg   <= 3'h0;
    end else begin
      if (wrSetup) begin
        setupReg <= regWdata & `ACC_SETUP_MASK;
      end
      if (wrCtrl) begin
        irqEnReg <= regWdata[`ACC_CTL_IE];
        selReg   <= regWdata[`ACC_CTL_SEL_HI:0];
      end
    end
  end

  // Previous-cycle copies; reset values match the idle pin and a cleared enable
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      trigPrevReg <= 1'b0;
      enPrevReg   <= 1'b0;
    end else begin
      trigPrevReg <= triggerInputPin;
      enPrevReg   <= convEn;
    end
  end

  // One enable flop per shared pin
  genvar pinIdx;
  generate
    for (pinIdx = 0; pinIdx < 8; pinIdx = pinIdx + 1) begin : g_pin
      always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
          pinEnReg[pinIdx] <= 1'b0;
        end else if (wrChan) begin
          pinEnReg[pinIdx] <= regWdata[pinIdx];
        end
      end
    end
  endgenerate

  // Flags; a set in the same cycle as a clear wins
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      flagReg   <= 1'b0;
      readyReg  <= 1'b0;
      resultReg <= `ACC_RES_RST;
    end else begin
      if (loadNow) begin
        flagReg <= 1'b1;
      end else if (flagClr) begin
        flagReg <= 1'b0;
      end
      if (loadNow) begin
        readyReg <= 1'b1;
      end else if (startReq) begin
        readyReg <= 1'b0;
      end
      // Dummy completion leaves the reset data in place
      if (doneNow) begin
        resultReg <= sarReg;
      end
    end
  end

  // Dummy completion is offered once after reset
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      firstPendReg <= 1'b1;
    end else if (dummyNow) begin
      firstPendReg <= 1'b0;
    end
  end

  // Conversion sequencer: sample for some converter clocks, then one bit per clock
  // Clearing the enable aborts a conversion and keeps the old result
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      stateReg <= ST_IDLE;
      cntReg   <= 4'h0;
    end else if (!convEn) begin
      stateReg <= ST_IDLE;
      cntReg   <= 4'h0;
    end else begin
      case (stateReg)
        ST_IDLE: begin
          if (startReq) begin
            cntReg   <= 4'h0;
            stateReg <= ST_SAMPLE;
          end
        end
        ST_SAMPLE: begin
          if (tick) begin
            if (sampleLast) begin
              cntReg   <= 4'h0;
              stateReg <= ST_SAR;
            end else begin
              cntReg <= cntReg + 4'h1;
            end
          end
        end
        ST_SAR: begin
          if (tick) begin
            if (sarLast) begin
              stateReg <= ST_DONE;
            end else begin
              cntReg <= cntReg + 4'h1;
            end
          end
        end
        ST_DONE: begin
          stateReg <= ST_IDLE;
        end
        default: begin
          stateReg <= ST_IDLE;
        end
      endcase
    end
  end

  // Channel latched once per conversion
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      chanReg <= 3'h0;
    end else if (startReq) begin
      chanReg <= selNow;
    end
  end

  // Result and trial registers, top bit tried first
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      sarReg   <= 10'h000;
      trialReg <= 10'h000;
    end else if (sampleDone) begin
      sarReg   <= 10'h200;
      trialReg <= 10'h200;
    end else if (sarActive && tick) begin
      sarReg   <= sarNext;
      trialReg <= trialReg >> 1;
    end
  end

  // Read data mux; unmapped addresses read zero
  always @* begin
    readMux = 16'h0000;
    case (regAddr)
      `ACC_ADDR_SETUP: readMux = setupReg;
      `ACC_ADDR_CTRL:  readMux = ctrlView;
      `ACC_ADDR_DATA:  readMux = dataView;
      `ACC_ADDR_CHAN:  readMux = chanView;
      default:         readMux = 16'h0000;
    endcase
  end

  // Read port, data valid only in the cycle after the strobe
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      regRdata <= 16'h0000;
    end else if (regRd) begin
      regRdata <= readMux;
    end else begin
      regRdata <= 16'h0000;
    end
  end
endmodule
`default_nettype wire

// file: bench/acc_props.sv
`timescale 1ns/1ps
`default_nettype none
`include "acc_defs.vh"
module acc_props (
  input wire logic        sys_clk,
  input wire logic        resetn,
  input wire logic [17:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire logic        regWr,
  input wire logic        regRd,
  input wire logic [15:0] regRdata,
  input wire logic        standbyMode,
  input wire logic        biasPowerOn,
  input wire logic        sampleHold,
  input wire logic        sarActive,
  input wire logic [2:0]  channelLatched,
  input wire logic [7:0]  pinAnalogEnable,
  input wire logic        convIrq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  wire ctlWr = regWr && regAddr == `ACC_ADDR_CTRL;
  property p_bias; standbyMode |-> !biasPowerOn; endproperty
  a_bias: assert property (p_bias) else $error("bias on in standby");
  property p_dlow; regRd && regAddr == `ACC_ADDR_DATA |=> regRdata[5:0] == 6'h0; endproperty
  a_dlow: assert property (p_dlow) else $error("data low bits set");
  property p_chi; regRd && regAddr == `ACC_ADDR_CHAN |=> regRdata[15:8] == 8'h00; endproperty
  a_chi: assert property (p_chi) else $error("pin enable high bits set");
  property p_pins;
    regWr && regAddr == `ACC_ADDR_CHAN |=> pinAnalogEnable == $past(regWdata[7:0]);
  endproperty
  a_pins: assert property (p_pins) else $error("pin enables wrong");
  property p_latch; sarActive && $past(sampleHold || sarActive) |-> $stable(channelLatched);
  endproperty
  a_latch: assert property (p_latch) else $error("channel moved mid conversion");
  property p_irq; $fell(convIrq) |-> $past(ctlWr); endproperty
  a_irq: assert property (p_irq) else $error("irq dropped without write");
  property p_sar; $rose(sarActive) |-> sarActive [*8]; endproperty
  a_sar: assert property (p_sar) else $error("trial phase too short");
  property p_sel;
    $rose(sampleHold) && $past(ctlWr) |-> channelLatched == $past(regWdata[2:0]);
  endproperty
  a_sel: assert property (p_sel) else $error("wrong channel latched");
  c_irq: cover property (convIrq);
  c_sar: cover property ($rose(sarActive));
  c_stby: cover property (standbyMode && !biasPowerOn);
endmodule
`default_nettype wire

// file: bench/acc_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module acc_core_model (
  input  wire logic       sarActive,
  input  wire logic [2:0] channelLatched,
  output wire logic       compareIn
);
  // Odd channels at full scale, even ones at ground
  assign compareIn = sarActive & channelLatched[0];
endmodule
`default_nettype wire

// file: bench/test_adc_conversion_control.sv
`timescale 1ns/1ps
`default_nettype none
`include "acc_defs.vh"
module test_adc_conversion_control;
  localparam logic [17:0] SET = `ACC_ADDR_SETUP;
  localparam logic [17:0] CTL = `ACC_ADDR_CTRL;
  localparam logic [17:0] DAT = `ACC_ADDR_DATA;
  localparam logic [17:0] CHN = `ACC_ADDR_CHAN;
  logic sys_clk, resetn, regWr, regRd, trig, tmr, stby;
  logic [17:0] regAddr;
  logic [15:0] regWdata, d;
  wire  [15:0] rdata;
  wire  [7:0]  pae;
  wire  [2:0]  chl;
  wire         bias, sh, sar, cmp, irq;
  int          num_errors = 0;
  int          n_compared = 0;
  adc_conversion_control u_dut (
    .sys_clk(sys_clk), .resetn(resetn), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(rdata), .triggerInputPin(trig),
    .timerEvent(tmr), .standbyMode(stby), .biasPowerOn(bias), .sampleHold(sh),
    .sarActive(sar), .channelLatched(chl), .pinAnalogEnable(pae),
    .compareIn(cmp), .convIrq(irq));
  acc_core_model u_core (.sarActive(sar), .channelLatched(chl), .compareIn(cmp));
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [17:0] a, input logic [15:0] v);
    @(posedge sys_clk);
    regAddr  <= a;
    regWdata <= v;
    regWr    <= 1'b1;
    @(posedge sys_clk);
    regWr <= 1'b0;
    #1;
  endtask
  task automatic rc(input logic [17:0] a, input logic [15:0] m, input logic [15:0] e);
    @(posedge sys_clk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge sys_clk);
    regRd <= 1'b0;
    #1 d = rdata;
    if (m != 16'h0000) chk(d & m, e);
  endtask
  task automatic complete_run;
    $display("compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic wait_rdy;
    d = 16'h0000;
    for (int i = 0; i < 3000 && d[7] !== 1'b1; i++)
      rc(CTL, 16'h0000, 16'h0000);
    if (d[7] !== 1'b1) begin
      num_errors++;
      $display("unexpected at %0t: ready never set", $time);
      complete_run();
    end
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  initial begin
    {resetn, regWr, regRd, trig, tmr, stby} = 6'h00;
    regAddr = 18'h0_0000;
    regWdata = 16'h0000;
    repeat (6) @(posedge sys_clk);
    resetn <= 1'b1;
    rc(SET, 16'hFFFF, 16'h8000);
    rc(CTL, 16'hFFFF, 16'h0000);
    rc(DAT, 16'hFFFF, 16'hFFC0);
    wr(CHN, 16'h01A5);
    rc(CHN, 16'hFFFF, 16'h00A5);
    chk(16'(pae), 16'h00A5);
    rc(18'h0_0010, 16'hFFFF, 16'h0000);
    wr(CTL, 16'h0040);
    repeat (20) @(posedge sys_clk);
    chk(16'(sh), 16'h0000);
    $display("reset test done");
    wr(SET, 16'hC600);
    rc(CTL, 16'h8080, 16'h8080);
    rc(DAT, 16'hFFFF, 16'hFFC0);
    wr(CTL, 16'hC042);
    rc(CTL, 16'h0080, 16'h0000);
    wr(CTL, 16'h4043);
    chk(16'(chl), 16'h0002);
    wait_rdy();
    rc(DAT, 16'hFFFF, 16'h0000);
    rc(CTL, 16'hC087, 16'hC083);
    wr(CTL, 16'h4003);
    chk(16'(irq), 16'h0001);
    wr(CTL, 16'h8003);
    rc(CTL, 16'hC087, 16'h0083);
    chk(16'(irq), 16'h0000);
    $display("manual test done");
    wr(SET, 16'hC680);
    wr(CTL, 16'h8005);
    @(posedge sys_clk) tmr <= 1'b1;
    @(posedge sys_clk) tmr <= 1'b0;
    wait_rdy();
    rc(DAT, 16'hFFFF, 16'hFFC0);
    chk(16'(chl), 16'h0005);
    wr(SET, 16'hC500);
    wr(CTL, 16'h8004);
    @(posedge sys_clk) trig <= 1'b1;
    repeat (3) @(posedge sys_clk);
    trig <= 1'b0;
    wait_rdy();
    rc(DAT, 16'hFFFF, 16'h0000);
    chk(16'(chl), 16'h0004);
    $display("trigger test done");
    @(posedge sys_clk) stby <= 1'b1;
    @(posedge sys_clk);
    #1 chk(16'(bias), 16'h0000);
    $display("standby test done");
    complete_run();
  end
endmodule
bind adc_conversion_control acc_props u_props (
  .sys_clk(sys_clk), .resetn(resetn), .regAddr(regAddr), .regWdata(regWdata),
  .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .standbyMode(standbyMode),
  .biasPowerOn(biasPowerOn), .sampleHold(sampleHold), .sarActive(sarActive),
  .channelLatched(channelLatched), .pinAnalogEnable(pinAnalogEnable), .convIrq(convIrq));
`default_nettype wire
